// >>> hw/lcia_top.sv
// Behaviour
// - Master enable off blocks channel's interrupts
// - Master enable on passes enabled source interrupts
// - Channels 0-5 enables at 0x60 bits 0-5
// - Channels 6-11 enables at 0xE0 bits 0-5
// - Pending bit shows any unserviced channel interrupt
// - Pending bits at 0x61 and 0xE1
// - Pending stays until source status read
// - Fixed part identifier at 0x6E
// - Revision at 0x6F, upper nibble zero
// - Receiver-on bit zero disables receiver
// - Channels 9-11 receiver-on at 0x88 bits 3-5
// - Source status clears on read
// - Four source events, both edges
`timescale 1ns/10ps
`default_nettype none
module lcia_top #(
    parameter logic [7:0] PART_ID = 8'h5A,  // Arbitrary identifier value
    parameter logic [3:0] REVISION = 4'h3   // Arbitrary revision value
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cpu_cs_in,
    input wire logic cpu_rd_in,
    input wire logic cpu_wr_in,
    input wire logic [7:0] cpu_addr_in,
    input wire logic [7:0] cpu_wdata_in,
    input wire logic [lcia_pkg::NUM_CHAN-1:0] drive_monitor_flag_in,
    input wire logic [lcia_pkg::NUM_CHAN-1:0] signal_loss_flag_in,
    input wire logic [lcia_pkg::NUM_CHAN-1:0] lock_loss_flag_in,
    input wire logic [lcia_pkg::NUM_CHAN-1:0] fifo_limit_flag_in,
    output logic [7:0] cpu_rdata_out,
    output logic cpu_rvalid_out,
    output logic irq_n_out,
    output logic [lcia_pkg::NUM_CHAN-1:0] receiver_power_on_out
);
    import lcia_pkg::*;

    lcia_top_s st_q;               // Registered state
    lcia_top_s st_d;               // Next state
    logic rd_stb;                  // Qualified read strobe
    logic wr_stb;                  // Qualified write strobe
    logic [NUM_CHAN-1:0] pend;     // Channel pending bits
    logic [NUM_CHAN-1:0] en_all;   // Master enables, channel order
    logic [NUM_SRC-1:0] src_en_v [NUM_CHAN];  // Source enables per channel
    logic [NUM_SRC-1:0] status_v [NUM_CHAN];  // Source status per channel

    // Strobes only count with chip select
    assign rd_stb = cpu_cs_in && cpu_rd_in;
    assign wr_stb = cpu_cs_in && cpu_wr_in;
    assign en_all = {st_q.en_hi, st_q.en_lo};

    // One source block per channel, decoded from its address nibble
    generate
        for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
            localparam logic [3:0] NIB = lcia_chan_nib(g);
            lcia_chan u_chan (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .flags_in({fifo_limit_flag_in[g], lock_loss_flag_in[g],
                           signal_loss_flag_in[g], drive_monitor_flag_in[g]}),
                .src_en_wr_in(wr_stb && cpu_addr_in == {NIB, LO_SRC_ENABLE}),
                .src_en_wdata_in(cpu_wdata_in[NUM_SRC-1:0]),
                // Only the status read releases pending
                .status_rd_in(rd_stb && cpu_addr_in == {NIB, LO_SRC_STATUS}),
                .src_en_out(src_en_v[g]),
                .status_out(status_v[g]),
                .pending_out(pend[g])
            );
        end
    endgenerate

    // Register writes, read mux and interrupt pin
    always_comb begin
        st_d = st_q;
        st_d.rvalid = rd_stb;
        if (wr_stb) begin
            case (cpu_addr_in)
                ADDR_CHAN_LOW_IRQ_ENABLE: st_d.en_lo = cpu_wdata_in[5:0];
                ADDR_CHAN_HIGH_IRQ_ENABLE: st_d.en_hi = cpu_wdata_in[5:0];
                // Receiver on, channels 0-5 and 6-11
                ADDR_RX_ON_LO: st_d.rx_on[5:0] = cpu_wdata_in[5:0];
                ADDR_RX_ON_HI: st_d.rx_on[11:6] = cpu_wdata_in[5:0];
                // Read-only and unmapped addresses drop writes
                default: st_d.rx_on = st_q.rx_on;
            endcase
        end
        if (rd_stb) begin
            // Unmapped reads return zero
            st_d.rdata = RST_RDATA;
            case (cpu_addr_in)
                ADDR_CHAN_LOW_IRQ_ENABLE: st_d.rdata = {2'b00, st_q.en_lo};
                ADDR_CHAN_HIGH_IRQ_ENABLE: st_d.rdata = {2'b00, st_q.en_hi};
                // Pending bits, low and high halves
                ADDR_CHAN_LOW_IRQ_PENDING: st_d.rdata = {2'b00, pend[5:0]};
                ADDR_CHAN_HIGH_IRQ_PENDING: st_d.rdata = {2'b00, pend[11:6]};
                ADDR_RX_ON_LO: st_d.rdata = {2'b00, st_q.rx_on[5:0]};
                ADDR_RX_ON_HI: st_d.rdata = {2'b00, st_q.rx_on[11:6]};
                ADDR_PART_IDENTIFIER: st_d.rdata = PART_ID;
                ADDR_SILICON_REVISION: st_d.rdata = {4'h0, REVISION};
                default: st_d.rdata = RST_RDATA;
            endcase
            // Per-channel enable and status words; data is pre-clear value
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (cpu_addr_in == {lcia_chan_nib(i), LO_SRC_ENABLE}) begin
                    st_d.rdata = {4'h0, src_en_v[i]};
                end
                if (cpu_addr_in == {lcia_chan_nib(i), LO_SRC_STATUS}) begin
                    st_d.rdata = {4'h0, status_v[i]};
                end
            end
        end
        // OR of enabled pendings, active low
        st_d.irq_n = ~|(pend & en_all);
    end

    // State register; pin idles high through reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '{en_lo: RST_CHAN_ENABLE, en_hi: RST_CHAN_ENABLE,
                      rx_on: RST_RX_ON, rdata: RST_RDATA,
                      rvalid: 1'b0, irq_n: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state flops; line-input tristate lives in the pad ring
    assign cpu_rdata_out = st_q.rdata;
    assign cpu_rvalid_out = st_q.rvalid;
    assign irq_n_out = st_q.irq_n;
    assign receiver_power_on_out = st_q.rx_on;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_mask_blocks_irq: assert property (
        (pend & en_all) == 12'h000 |=> irq_n_out)
        else $error("irq asserted by masked channel");
    a_enabled_irq_out: assert property (
        (pend & en_all) != 12'h000 |=> !irq_n_out)
        else $error("enabled pending did not assert irq");
    a_irq_follows_or: assert property (
        ##1 irq_n_out == !$past(|(pend & en_all)))
        else $error("irq not OR of enabled pendings");
    a_low_enable_wr: assert property (
        wr_stb && cpu_addr_in == ADDR_CHAN_LOW_IRQ_ENABLE
        |=> en_all[5:0] == $past(cpu_wdata_in[5:0]))
        else $error("low enable write lost");
    a_high_enable_wr: assert property (
        wr_stb && cpu_addr_in == ADDR_CHAN_HIGH_IRQ_ENABLE
        |=> en_all[11:6] == $past(cpu_wdata_in[5:0]))
        else $error("high enable write lost");
    a_pending_readback: assert property (
        rd_stb && cpu_addr_in == ADDR_CHAN_HIGH_IRQ_PENDING
        |=> cpu_rvalid_out && cpu_rdata_out == {2'b00, $past(pend[11:6])})
        else $error("high pending readback wrong");
    a_part_id_read: assert property (
        rd_stb && cpu_addr_in == ADDR_PART_IDENTIFIER |=> cpu_rdata_out == PART_ID)
        else $error("part identifier wrong");
    a_revision_read: assert property (
        rd_stb && cpu_addr_in == ADDR_SILICON_REVISION
        |=> cpu_rdata_out == {4'h0, REVISION})
        else $error("revision wrong");
    a_rx_on_high_wr: assert property (
        wr_stb && cpu_addr_in == ADDR_RX_ON_HI
        |=> receiver_power_on_out[11:6] == $past(cpu_wdata_in[5:0]))
        else $error("receiver-on write lost");
    a_reserved_zero: assert property (
        rd_stb && cpu_addr_in == ADDR_CHAN_LOW_IRQ_ENABLE |=> cpu_rdata_out[7:6] == 2'b00)
        else $error("reserved bits not zero");

    c_irq_raised: cover property (irq_n_out ##1 !irq_n_out);
    c_irq_released: cover property (!irq_n_out ##1 irq_n_out);
    c_rx_off: cover property (wr_stb && cpu_addr_in == ADDR_RX_ON_LO ##1 receiver_power_on_out == 12'h000);
endmodule
`default_nettype wire

// >>> pkg/lcia_pkg.sv
`default_nettype none
package lcia_pkg;
    // Channel count and source events per channel
    localparam int NUM_CHAN = 12;
    localparam int HALF_CHAN = 6;
    localparam int NUM_SRC = 4;
    // Source bit positions inside the per-channel enable and status words
    localparam int SRC_DRIVE_MON = 0;
    localparam int SRC_SIG_LOSS = 1;
    localparam int SRC_LOCK_LOSS = 2;
    localparam int SRC_FIFO_LIM = 3;
    // Global register byte addresses
    localparam logic [7:0] ADDR_RX_ON_LO = 8'h08;
    localparam logic [7:0] ADDR_RX_ON_HI = 8'h88;
    localparam logic [7:0] ADDR_CHAN_LOW_IRQ_ENABLE = 8'h60;
    localparam logic [7:0] ADDR_CHAN_LOW_IRQ_PENDING = 8'h61;
    localparam logic [7:0] ADDR_CHAN_HIGH_IRQ_ENABLE = 8'hE0;
    localparam logic [7:0] ADDR_CHAN_HIGH_IRQ_PENDING = 8'hE1;
    localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'h6E;
    localparam logic [7:0] ADDR_SILICON_REVISION = 8'h6F;
    // Low nibble of per-channel registers; high nibble picks the channel
    localparam logic [3:0] LO_SRC_ENABLE = 4'h1;
    localparam logic [3:0] LO_SRC_STATUS = 4'h2;
    localparam logic [3:0] NIB_HIGH_SKIP = 4'h2;
    // Values after reset
    localparam logic [5:0] RST_CHAN_ENABLE = 6'h00;
    localparam logic [11:0] RST_RX_ON = 12'h000;
    localparam logic [NUM_SRC-1:0] RST_SRC = 4'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // High nibble of a channel's register block: 0-5, then 8-D
    function automatic logic [3:0] lcia_chan_nib(input int ch);
        logic [3:0] nib;
        nib = 4'(ch);
        if (ch >= HALF_CHAN) begin
            nib = 4'(ch) + NIB_HIGH_SKIP;
        end
        return nib;
    endfunction

    // Per-channel state
    typedef struct packed {
        logic [NUM_SRC-1:0] src_en;
        logic [NUM_SRC-1:0] flag_prev;
        logic [NUM_SRC-1:0] status;
    } lcia_chan_s;

    // Chip-level state
    typedef struct packed {
        logic [5:0] en_lo;
        logic [5:0] en_hi;
        logic [11:0] rx_on;
        logic [7:0] rdata;
        logic rvalid;
        logic irq_n;
    } lcia_top_s;
endpackage
`default_nettype wire

// >>> hw/lcia_chan.sv
`timescale 1ns/10ps
`default_nettype none
module lcia_chan (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [lcia_pkg::NUM_SRC-1:0] flags_in,
    input wire logic src_en_wr_in,
    input wire logic [lcia_pkg::NUM_SRC-1:0] src_en_wdata_in,
    input wire logic status_rd_in,
    output logic [lcia_pkg::NUM_SRC-1:0] src_en_out,
    output logic [lcia_pkg::NUM_SRC-1:0] status_out,
    output logic pending_out
);
    import lcia_pkg::*;

    lcia_chan_s st_q;     // Registered state
    lcia_chan_s st_d;     // Next state
    logic [NUM_SRC-1:0] evt; // Enabled edges this cycle

    // Next-state logic
    always_comb begin
        st_d = st_q;
        evt = (flags_in ^ st_q.flag_prev) & st_q.src_en;
        st_d.flag_prev = flags_in;
        if (src_en_wr_in) begin
            st_d.src_en = src_en_wdata_in;
        end
        // Clear on read, new edge wins
        if (status_rd_in) begin
            st_d.status = evt;
        end else begin
            st_d.status = st_q.status | evt;
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '{src_en: RST_SRC, flag_prev: RST_SRC, status: RST_SRC};
        end else begin
            st_q <= st_d;
        end
    end

    assign src_en_out = st_q.src_en;
    assign status_out = st_q.status;
    // Pending while any status bit held
    assign pending_out = |st_q.status;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_read_clears_status: assert property (
        status_rd_in && ((flags_in ^ st_q.flag_prev) & st_q.src_en) == 4'h0
        |=> status_out == 4'h0)
        else $error("status not cleared by read");
    a_pending_holds: assert property (
        pending_out && !status_rd_in |=> pending_out)
        else $error("pending dropped without read");
    a_edge_sets_status: assert property (
        st_q.src_en[SRC_SIG_LOSS] && $changed(flags_in[SRC_SIG_LOSS])
        |-> ##1 status_out[SRC_SIG_LOSS] ##1 1'b1)
        else $error("enabled change missed");
    c_status_cleared: cover property (pending_out ##1 status_rd_in ##1 !pending_out);
endmodule
`default_nettype wire

// >>> verification/lcia_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host on the parallel bus: one strobe edge per access, then idle
module lcia_host_model (
    input wire logic clk_in,
    output logic cs_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    // Expected read data, oldest first
    logic [7:0] exp_q[$];

    initial begin
        cs_out = 1'b0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // Register block base of a channel: 0x00-0x50, then 0x80-0xD0
    function automatic logic [7:0] base(input int ch);
        return 8'((ch < 6) ? ch * 16 : ch * 16 + 32);
    endfunction

    // One access; random idle gap makes the host prompt or slow
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom_range(1, 0)) @(posedge clk_in);
        @(posedge clk_in);
        cs_out <= 1'b1;
        rd_out <= ~w;
        wr_out <= w;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        cs_out <= 1'b0;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // Released lines carry no stale value
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    // Read with the value the bench expects back
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, ~e);
    endtask

    // Service one pending channel
    // cause read after pending
    task automatic service(input int ch, input logic [3:0] cause);
        rd((ch < 6) ? 8'h61 : 8'hE1, 8'(1 << (ch % 6)));
        rd(base(ch) + 8'h02, {4'h0, cause});
    endtask
endmodule
`default_nettype wire

// >>> verification/lcia_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lcia_top_tb_top;
    import lcia_pkg::*;
    localparam logic [7:0] PID = 8'hC3;  // Arbitrary identifier
    localparam logic [3:0] REV = 4'h9;  // Arbitrary revision
    logic clk_in, rst_in, cs, rd, wr, rvalid, irq_n;
    logic [7:0] addr, wdata, rdata, v, mreg;
    logic [3:0][11:0] flg;  // Alarm levels per source
    logic [11:0] receiver_power_on;
    int error_cnt = 0;
    int n_checks = 0;

    lcia_top #(.PART_ID(PID), .REVISION(REV)) i_lcia_top (
        .clk_in(clk_in), .rst_in(rst_in), .cpu_cs_in(cs), .cpu_rd_in(rd),
        .cpu_wr_in(wr), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
        .drive_monitor_flag_in(flg[0]), .signal_loss_flag_in(flg[1]),
        .lock_loss_flag_in(flg[2]), .fifo_limit_flag_in(flg[3]),
        .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid), .irq_n_out(irq_n),
        .receiver_power_on_out(receiver_power_on)
    );
    lcia_host_model i_lcia_host_model (
        .clk_in(clk_in), .cs_out(cs), .rd_out(rd), .wr_out(wr),
        .addr_out(addr), .wdata_out(wdata)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Compare and count
    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Read data watcher: oldest note per valid pulse
    always @(posedge clk_in) begin
        if (rvalid === 1'b1) begin
            if (i_lcia_host_model.exp_q.size() == 0) begin
                check("unasked read", 12'h1, 12'h0);
            end else begin
                check("rdata", rdata, i_lcia_host_model.exp_q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        check("timeout", 12'h1, 12'h0);
        give_verdict();
    end

    initial begin
        int ch;
        int s;
        void'($urandom(32'hf8bbc268));
        rst_in = 1'b1;
        flg = '0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        // Reset values, identity, unmapped and read-only places
        i_lcia_host_model.rd(8'h60, 8'h00);
        i_lcia_host_model.rd(8'hE1, 8'h00);
        i_lcia_host_model.acc(1'b1, 8'h6E, ~PID);
        i_lcia_host_model.rd(8'h6E, PID);
        i_lcia_host_model.rd(8'h6F, {4'h0, REV});
        i_lcia_host_model.rd(8'h70, 8'h00);
        // Master enables keep only bits 5-0
        v = 8'($urandom);
        i_lcia_host_model.acc(1'b1, 8'h60, v);
        i_lcia_host_model.rd(8'h60, v & 8'h3F);
        i_lcia_host_model.acc(1'b1, 8'hE0, ~v);
        i_lcia_host_model.rd(8'hE0, ~v & 8'h3F);
        i_lcia_host_model.acc(1'b1, 8'h08, v);
        i_lcia_host_model.acc(1'b1, 8'h88, ~v);
        @(negedge clk_in);
        check("rx on", receiver_power_on, {~v[5:0], v[5:0]});
        // Receiver-on word reads back without the reserved bits
        i_lcia_host_model.rd(8'h88, ~v & 8'h3F);
        i_lcia_host_model.acc(1'b1, 8'h60, 8'h00);
        i_lcia_host_model.acc(1'b1, 8'hE0, 8'h00);
        // Alarm events: masked, then passed, then serviced
        for (int i = 0; i < 12; i++) begin
            ch = $urandom_range(11, 0);
            s = i % 4;
            mreg = (ch < 6) ? 8'h60 : 8'hE0;
            // Upper nibble of the source enable word is dropped
            i_lcia_host_model.acc(1'b1, i_lcia_host_model.base(ch) + 8'h01, 8'hFF);
            i_lcia_host_model.rd(i_lcia_host_model.base(ch) + 8'h01, 8'h0F);
            @(posedge clk_in);
            flg[s][ch] <= ~flg[s][ch];
            repeat (4) @(negedge clk_in);
            check("irq masked", irq_n, 12'h1);
            i_lcia_host_model.acc(1'b1, mreg, 8'(1 << (ch % 6)));
            repeat (3) @(negedge clk_in);
            check("irq raised", irq_n, 12'h0);
            i_lcia_host_model.service(ch, 4'(1 << s));
            repeat (3) @(negedge clk_in);
            check("irq cleared", irq_n, 12'h1);
            // A second status read finds nothing left
            i_lcia_host_model.rd(i_lcia_host_model.base(ch) + 8'h02, 8'h00);
            i_lcia_host_model.acc(1'b1, mreg, 8'h00);
        end
        // Source enable off: a flag change leaves no trace
        ch = $urandom_range(11, 0);
        i_lcia_host_model.acc(1'b1, i_lcia_host_model.base(ch) + 8'h01, 8'h00);
        @(posedge clk_in);
        flg[1][ch] <= ~flg[1][ch];
        i_lcia_host_model.acc(1'b1, (ch < 6) ? 8'h60 : 8'hE0, 8'h3F);
        repeat (3) @(negedge clk_in);
        check("irq refused", irq_n, 12'h1);
        i_lcia_host_model.rd((ch < 6) ? 8'h61 : 8'hE1, 8'h00);
        // Let outstanding reads land
        for (int k = 0; k < 20 && i_lcia_host_model.exp_q.size() > 0; k++) begin
            @(posedge clk_in);
        end
        check("reads left", 12'(i_lcia_host_model.exp_q.size()), 12'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
